// ### src/port_pins_pkg.sv
// shared constants, register map and carrier types of the port pin block
package port_pins_pkg;

  localparam int NUM_PORTS = 7;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_bus_t;

  // usable pins per port, port 0 in the low byte
  localparam port_bus_t PORT_MASK = {8'h0F, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [PORT_W-1:0] DIR_RESET = 8'h00;
  localparam logic [PORT_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [PORT_W-1:0] CTRL_RESET = 8'h00;

  // port n data latch at n*8, its direction register at n*8+4
  localparam int PORT_IDX_LSB = 3;
  localparam int DIR_SEL_BIT = 2;
  localparam logic [ADDR_W-1:0] PULL0_ADDR = 8'h38;
  localparam logic [ADDR_W-1:0] PULL5_ADDR = 8'h3C;
  localparam logic [ADDR_W-1:0] EXB_CTRL_ADDR = 8'h40;
  localparam logic [ADDR_W-1:0] SIO_CTRL_ADDR = 8'h44;
  localparam logic [ADDR_W-1:0] TMR_MODE_ADDR = 8'h48;
  localparam logic [ADDR_W-1:0] EDGE_SEL_ADDR = 8'h4C;

  localparam int EXB_EN_BIT = 0;
  localparam int EXB_DMA_BIT = 1;
  localparam int SIO_EN_BIT = 0;
  localparam int TMR_IO_BIT = 0;

  // port numbers and pin positions of the alternate functions
  localparam int P0 = 0;
  localparam int P3 = 3;
  localparam int P4 = 4;
  localparam int P5 = 5;
  localparam int P3_IRQ = 3;
  localparam int P3_SEL = 4;
  localparam int P3_WR = 5;
  localparam int P3_RD = 6;
  localparam int P3_A0 = 7;
  localparam int P4_RXD = 0;
  localparam int P4_TXD = 1;
  localparam int P4_SCLK = 2;
  localparam int P4_RDY = 3;
  localparam int P5_IRQ_A = 0;
  localparam int P5_TMR = 1;
  localparam int P5_IRQ_B = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic select;
    logic write_strobe;
    logic read_strobe;
    logic addr_bit0;
    logic addr_bit1;
    logic transfer_ack;
    logic terminal_count;
  } exb_in_s;

  typedef struct packed {
    logic rxd;
    logic sclk;
  } sio_in_s;

  typedef struct packed {
    logic txd;
    logic sclk;
    logic sclk_oe;
    logic ready;
  } sio_out_s;

endpackage

// ### src/port_pins.sv
// bidirectional port pins with alternate functions behind an axi4-lite slave
// Functional notes
// - every port pin has its own direction bit, set independently.
// - direction 0 makes the pin input, 1 drives it from its latch.
// - reading an output pin returns its latch, not the sensed pin level.
// - an input pin is driven only when an alternate function takes it over; otherwise its enable stays low.
// - writing an input pin updates only its latch; pin stays undriven.
// - port zero has pull-up controls and feeds the key-on wake-up request.
// - with external bus enabled, port three bit three drives its interrupt out.
// - with external bus enabled, port three bits four to seven are bus inputs.
// - port four carries serial or external bus signals as the control registers select.
// - port five bits zero and two feed external interrupts, with pull-ups, edge select.
// - port five bit one is the timer line under the timer mode register.
`timescale 1ns/1ps
module port_pins
  import port_pins_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire port_bus_t pin_in,
  output port_bus_t pin_out,
  output port_bus_t pin_oe,
  output logic [PORT_W-1:0] p0_pull_en,
  output logic [PORT_W-1:0] p5_pull_en,
  output logic key_wake_req,
  output logic ext_irq_line_a,
  output logic ext_irq_line_b,
  output logic [1:0] irq_edge_sel,
  output logic timer_io_line,
  output logic timer_io_en,
  input wire logic timer_out,
  input wire logic timer_oe,
  output logic exb_en,
  output logic exb_dma_en,
  input wire logic ext_bus_irq_out,
  input wire logic ext_bus_transfer_request,
  output exb_in_s exb_in,
  output logic sio_en,
  output sio_in_s sio_in,
  input wire sio_out_s sio_out
);

  port_bus_t latch;
  port_bus_t dir;
  port_bus_t next_out;
  port_bus_t next_oe;
  port_bus_t read_view;
  logic [PORT_W-1:0] exb_ctrl;
  logic [PORT_W-1:0] sio_ctrl;
  logic [PORT_W-1:0] tmr_mode;
  logic [PORT_W-1:0] edge_sel;
  logic wr_go;
  logic rd_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [PORT_W-1:0] wr_byte;
  logic wr_lane;
  logic ctrl_wr;
  logic wr_hit;
  logic rd_hit;
  logic [PORT_W-1:0] rd_byte;
  logic key_level;
  logic key_level_q;

  // ---------------- axi4-lite handshake ----------------
  // address and data are taken together; a lone one waits, since the
  // master holds valid, so no skid storage is needed
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_go;
  assign wr_addr = s_axi_awaddr;
  assign wr_byte = s_axi_wdata[PORT_W-1:0];
  // every register is one byte wide in the low lane
  assign wr_lane = s_axi_wstrb[0];

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] == 2'b00) begin
      if (int'(a[ADDR_W-1:PORT_IDX_LSB]) < NUM_PORTS) begin
        ok = 1'b1;
      end
      if (a == PULL0_ADDR || a == PULL5_ADDR || a == EXB_CTRL_ADDR ||
          a == SIO_CTRL_ADDR || a == TMR_MODE_ADDR || a == EDGE_SEL_ADDR) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction

  assign wr_hit = addr_mapped(wr_addr);
  assign rd_hit = addr_mapped(s_axi_araddr);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- port latches and direction ----------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic sel_port;
    assign sel_port = wr_go && wr_lane && (wr_addr[1:0] == 2'b00) &&
                      (int'(wr_addr[ADDR_W-1:PORT_IDX_LSB]) == p);

    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        latch[p] <= LATCH_RESET;
      end else if (sel_port && !wr_addr[DIR_SEL_BIT]) begin
        latch[p] <= wr_byte & PORT_MASK[p];
      end
    end

    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        dir[p] <= DIR_RESET;
      end else if (sel_port && wr_addr[DIR_SEL_BIT]) begin
        dir[p] <= wr_byte & PORT_MASK[p];
      end
    end

    assign read_view[p] = ((dir[p] & latch[p]) | (~dir[p] & pin_in[p])) & PORT_MASK[p];
  end

  // ---------------- control registers ----------------
  // a cleared low strobe lane stores nothing but still answers okay
  assign ctrl_wr = wr_go && wr_lane;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      p0_pull_en <= CTRL_RESET;
    end else if (ctrl_wr && wr_addr == PULL0_ADDR) begin
      p0_pull_en <= wr_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      p5_pull_en <= CTRL_RESET;
    end else if (ctrl_wr && wr_addr == PULL5_ADDR) begin
      p5_pull_en <= wr_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      exb_ctrl <= CTRL_RESET;
    end else if (ctrl_wr && wr_addr == EXB_CTRL_ADDR) begin
      exb_ctrl <= wr_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sio_ctrl <= CTRL_RESET;
    end else if (ctrl_wr && wr_addr == SIO_CTRL_ADDR) begin
      sio_ctrl <= wr_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tmr_mode <= CTRL_RESET;
    end else if (ctrl_wr && wr_addr == TMR_MODE_ADDR) begin
      tmr_mode <= wr_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      edge_sel <= CTRL_RESET;
    end else if (ctrl_wr && wr_addr == EDGE_SEL_ADDR) begin
      edge_sel <= wr_byte;
    end
  end

  assign exb_en = exb_ctrl[EXB_EN_BIT];
  assign exb_dma_en = exb_ctrl[EXB_DMA_BIT];
  assign sio_en = sio_ctrl[SIO_EN_BIT];
  assign timer_io_en = tmr_mode[TMR_IO_BIT];
  assign irq_edge_sel = edge_sel[1:0];

  // ---------------- register read ----------------
  always_comb begin
    rd_byte = '0;
    if (s_axi_araddr == PULL0_ADDR) begin
      rd_byte = p0_pull_en;
    end else if (s_axi_araddr == PULL5_ADDR) begin
      rd_byte = p5_pull_en;
    end else if (s_axi_araddr == EXB_CTRL_ADDR) begin
      rd_byte = exb_ctrl;
    end else if (s_axi_araddr == SIO_CTRL_ADDR) begin
      rd_byte = sio_ctrl;
    end else if (s_axi_araddr == TMR_MODE_ADDR) begin
      rd_byte = tmr_mode;
    end else if (s_axi_araddr == EDGE_SEL_ADDR) begin
      rd_byte = edge_sel;
    end else if (rd_hit) begin
      if (s_axi_araddr[DIR_SEL_BIT]) begin
        rd_byte = dir[s_axi_araddr[ADDR_W-1:PORT_IDX_LSB]];
      end else begin
        rd_byte = read_view[s_axi_araddr[ADDR_W-1:PORT_IDX_LSB]];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {{(DATA_W-PORT_W){1'b0}}, rd_byte};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- pin drive with alternate functions ----------------
  always_comb begin
    next_out = latch & PORT_MASK;
    next_oe = dir & PORT_MASK;
    if (exb_en) begin
      next_out[P3][P3_IRQ] = ext_bus_irq_out;
      next_oe[P3][P3_IRQ] = 1'b1;
      next_oe[P3][P3_A0:P3_SEL] = '0;
    end
    if (sio_en) begin
      next_oe[P4][P4_RXD] = 1'b0;
      next_out[P4][P4_TXD] = sio_out.txd;
      next_oe[P4][P4_TXD] = 1'b1;
      next_out[P4][P4_SCLK] = sio_out.sclk;
      next_oe[P4][P4_SCLK] = sio_out.sclk_oe;
      next_out[P4][P4_RDY] = sio_out.ready;
      next_oe[P4][P4_RDY] = 1'b1;
    end else if (exb_en && exb_dma_en) begin
      next_out[P4][P4_RXD] = ext_bus_transfer_request;
      next_oe[P4][P4_RXD] = 1'b1;
      next_oe[P4][P4_RDY:P4_TXD] = '0;
    end
    if (timer_io_en) begin
      next_out[P5][P5_TMR] = timer_out;
      next_oe[P5][P5_TMR] = timer_oe;
    end
  end

  // outputs from flip-flops so pads see no glitches from the decode
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
    end
  end

  // ---------------- alternate-function inputs ----------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      exb_in <= '0;
      sio_in <= '0;
      ext_irq_line_a <= 1'b0;
      ext_irq_line_b <= 1'b0;
      timer_io_line <= 1'b0;
    end else begin
      exb_in.select <= pin_in[P3][P3_SEL];
      exb_in.write_strobe <= pin_in[P3][P3_WR];
      exb_in.read_strobe <= pin_in[P3][P3_RD];
      exb_in.addr_bit0 <= pin_in[P3][P3_A0];
      exb_in.transfer_ack <= pin_in[P4][P4_TXD];
      exb_in.terminal_count <= pin_in[P4][P4_SCLK];
      exb_in.addr_bit1 <= pin_in[P4][P4_RDY];
      sio_in.rxd <= pin_in[P4][P4_RXD];
      sio_in.sclk <= pin_in[P4][P4_SCLK];
      ext_irq_line_a <= pin_in[P5][P5_IRQ_A];
      ext_irq_line_b <= pin_in[P5][P5_IRQ_B];
      timer_io_line <= pin_in[P5][P5_TMR];
    end
  end

  // ---------------- key-on wake-up ----------------
  // output pins count as high, so only input-mode pins can raise a request
  assign key_level = &(pin_in[P0] | dir[P0]);

  // previous level tracks the pins through reset too; a fixed reset value
  // would fake a falling edge right after release whenever a key is down
  always_ff @(posedge sys_clk) begin
    key_level_q <= key_level;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      key_wake_req <= 1'b0;
    end else begin
      key_wake_req <= key_level_q && !key_level;
    end
  end

endmodule // port_pins

// ### testbench/port_pins_asserts.sv
// checker for the port pin block
`timescale 1ns/1ps
module port_pins_asserts
  import port_pins_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire port_bus_t pin_in,
  input wire port_bus_t pin_out,
  input wire port_bus_t pin_oe,
  input wire logic key_wake_req,
  input wire logic ext_irq_line_a,
  input wire logic timer_io_en,
  input wire logic timer_oe,
  input wire logic exb_en,
  input wire logic ext_bus_irq_out
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write answer late");
  read_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read answer late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  oe_mask_a: assert property ((pin_oe & ~PORT_MASK) == '0)
    else $error("absent pin driven");
  reset_idle_a: assert property (disable iff (1'b0) sys_rst |=> pin_oe == '0)
    else $error("pin driven after reset");
  irq_copy_a: assert property (!sys_rst |=> ext_irq_line_a == $past(pin_in[P5][P5_IRQ_A]))
    else $error("irq line not sampled");
  exb_irq_pin_a: assert property (exb_en |=>
    pin_oe[P3][P3_IRQ] && pin_out[P3][P3_IRQ] == $past(ext_bus_irq_out))
    else $error("bus irq pin wrong");
  exb_inputs_a: assert property (exb_en |=> pin_oe[P3][7:4] == 4'h0)
    else $error("bus input pin driven");
  timer_pin_a: assert property (timer_io_en |=> pin_oe[P5][P5_TMR] == $past(timer_oe))
    else $error("timer pin enable wrong");
  wake_pulse_a: assert property (key_wake_req |=> !key_wake_req)
    else $error("wake pulse too long");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (key_wake_req);
endmodule // port_pins_asserts
bind port_pins port_pins_asserts chk (.*);

// ### testbench/pin_board.sv
// board model: circuits hanging on the port pins
`timescale 1ns/1ps
module pin_board
  import port_pins_pkg::*;
(
  input wire port_bus_t pin_out,
  input wire port_bus_t pin_oe,
  input wire port_bus_t board_drv,
  output port_bus_t pin_in
);
  // board drivers are weak: a pin the device drives shows the device level
  assign pin_in = (pin_out & pin_oe) | (board_drv & ~pin_oe);
endmodule // pin_board

// ### testbench/tb_bidirectional_port_pins.sv
// self-checking bench for the port pin block
`timescale 1ns/1ps
module tb_bidirectional_port_pins;
  import port_pins_pkg::*;
  logic sys_clk = 0;
  logic sys_rst = 1;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, key_wake_req, sio_en;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, irq_edge_sel, rs;
  logic [PORT_W-1:0] p0_pull_en, p5_pull_en, d, l, m;
  port_bus_t pin_in, pin_out, pin_oe, board_drv;
  logic ext_irq_line_a, ext_irq_line_b, timer_io_line, timer_io_en, timer_out, timer_oe;
  logic exb_en, exb_dma_en, ext_bus_irq_out, ext_bus_transfer_request;
  exb_in_s exb_in;
  sio_in_s sio_in;
  sio_out_s sio_out;
  int err_count = 0;
  int n_tests = 0;
  int i;
  integer seed = 32'h9b4a536e;
  port_pins dut (.*);
  pin_board board (.*);
  always #2.5 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do @(posedge sys_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    // pins follow a register one edge later, pin samples one edge after that
    repeat (2) @(posedge sys_clk);
  endtask
  // read answer held back one cycle so the slave must keep it
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1;
    @(posedge sys_clk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  function automatic logic [7:0] exp_rd(int p, logic [7:0] dv, logic [7:0] lv, logic [7:0] bv);
    return ((lv & dv) | (bv & ~dv)) & PORT_MASK[p];
  endfunction
  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_rready, s_axi_bready} <= 5'h01;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {48'h0, 4'hF};
    {timer_out, timer_oe, ext_bus_irq_out, ext_bus_transfer_request, sio_out} <= '0;
    board_drv <= '0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    for (int p = 0; p < NUM_PORTS; p++) begin
      rdr(8'(p * 8 + 4));
      chk("dir_reset", 0, rd);
    end
    chk("oe_reset", 0, pin_oe);
    $display("test reset done");
    for (int k = 0; k < 14; k++) begin
      d = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($random(seed));
      l = 8'($random(seed));
      board_drv <= port_bus_t'({$random(seed), $random(seed)});
      wr(8'(k % 7 * 8 + 4), 8'h00);
      wr(8'(k % 7 * 8), l);
      chk("oe_input_write", 0, pin_oe[k % 7]);
      wr(8'(k % 7 * 8 + 4), d);
      m = d & PORT_MASK[k % 7];
      chk("oe_dir", m, pin_oe[k % 7]);
      chk("out_latch", l & m, pin_out[k % 7] & m);
      rdr(8'(k % 7 * 8));
      chk("read_port", exp_rd(k % 7, d, l, board_drv[k % 7]), rd);
    end
    $display("test direction done");
    rdr(8'h50);
    chk("unmapped_read", {RESP_SLVERR, 32'h0}, {rs, rd});
    wr(8'h02, 8'h5A);
    chk("unmapped_write", RESP_SLVERR, rs);
    $display("test unmapped done");
    ext_bus_irq_out <= 1;
    wr(8'(P3 * 8 + 4), 8'hFF);
    wr(EXB_CTRL_ADDR, 8'h03);
    chk("bus_irq_pin", 2'b11, {pin_oe[P3][P3_IRQ], pin_out[P3][P3_IRQ]});
    chk("bus_in_oe", 0, pin_oe[P3][7:4]);
    chk("bus_select", board_drv[P3][P3_SEL], exb_in.select);
    ext_bus_transfer_request <= 1;
    wr(8'(P4 * 8 + 4), 8'h0F);
    chk("dma_req_pin", 2'b11, {pin_oe[P4][P4_RXD], pin_out[P4][P4_RXD]});
    chk("bus_inputs", {board_drv[P3][P3_SEL], board_drv[P3][P3_WR],
      board_drv[P3][P3_RD], board_drv[P3][P3_A0], board_drv[P4][P4_RDY],
      board_drv[P4][P4_TXD], board_drv[P4][P4_SCLK]}, exb_in);
    sio_out <= 4'b1010;
    wr(SIO_CTRL_ADDR, 8'h01);
    chk("sio_pins", 5'b11001, {pin_oe[P4][2:0], pin_out[P4][2:1]});
    chk("bus_enables", 3'h7, {exb_en, exb_dma_en, sio_en});
    chk("sio_in", {board_drv[P4][P4_RXD], sio_out.sclk}, sio_in);
    $display("test alternate bus done");
    {timer_out, timer_oe} <= 2'b11;
    wr(8'(P5 * 8 + 4), 8'h00);
    wr(TMR_MODE_ADDR, 8'h01);
    chk("timer_pin", 2'b11, {pin_oe[P5][P5_TMR], pin_out[P5][P5_TMR]});
    chk("timer_line", 2'b11, {timer_io_en, timer_io_line});
    wr(PULL5_ADDR, 8'h05);
    wr(EDGE_SEL_ADDR, 8'h02);
    chk("irq_pull_edge", {8'h05, 2'h2}, {p5_pull_en, irq_edge_sel});
    chk("irq_lines", {board_drv[P5][P5_IRQ_B], board_drv[P5][P5_IRQ_A]},
      {ext_irq_line_b, ext_irq_line_a});
    board_drv[P0] <= 8'hFF;
    wr(8'(P0 * 8 + 4), 8'h00);
    wr(PULL0_ADDR, 8'hFF);
    chk("p0_pull", 8'hFF, p0_pull_en);
    board_drv[P0] <= 8'hF7;
    i = 0;
    repeat (5) begin
      @(posedge sys_clk);
      if (key_wake_req === 1'b1) i++;
    end
    chk("key_wake", 1, i);
    $display("test pins done");
    sys_rst <= 1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 0;
    repeat (2) @(posedge sys_clk);
    chk("rst_mid_pins", 0, {pin_oe, key_wake_req});
    rdr(8'(P3 * 8 + 4));
    chk("rst_mid_dir", 0, rd);
    $display("test mid reset done");
    complete_run();
  end
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
endmodule // tb_bidirectional_port_pins
